// [rtl/cmi_pkg.sv]
package cmi_pkg;
   // register offsets on the control bus
   localparam logic [7:0] CMI_OFS_DELAY_SWITCH = 8'h29;
   localparam logic [7:0] CMI_OFS_BRIGHTNESS   = 8'h2a;
   localparam logic [7:0] CMI_OFS_CONTRAST     = 8'h2b;
   localparam logic [7:0] CMI_OFS_SATURATION   = 8'h2c;
   localparam logic [7:0] CMI_OFS_MASK_FIRST   = 8'h2d;
   localparam logic [7:0] CMI_OFS_MASK_SECOND  = 8'h2e;

   // reset values
   localparam logic [7:0] CMI_RST_DELAY_SWITCH = 8'h00;
   localparam logic [7:0] CMI_RST_BRIGHTNESS   = 8'h80;
   localparam logic [7:0] CMI_RST_CONTRAST     = 8'h40;
   localparam logic [7:0] CMI_RST_SATURATION   = 8'h40;
   localparam logic [7:0] CMI_RST_MASK         = 8'h00;

   // field positions in the delay/switch register
   localparam int CMI_BIT_SWITCH_ENABLE   = 7;
   localparam int CMI_BIT_SWITCH_POLARITY = 6;
   localparam int CMI_BIT_STATIC_SELECT   = 6;
   localparam int CMI_POS_SWITCH_DELAY    = 4;
   localparam int CMI_BIT_LUMA_PEAKING    = 3;
   localparam int CMI_POS_COMP_DELAY      = 0;

   // writable bits of the mask registers
   localparam logic [7:0] CMI_MASK_FIRST_BITS  = 8'h1d;
   localparam logic [7:0] CMI_MASK_SECOND_BITS = 8'h43;

   // pixel pipeline depth: centre tap so that negative shifts can be made
   localparam int CMI_SWITCH_CENTRE = 2;
   localparam int CMI_COMP_CENTRE   = 16;
   localparam int CMI_COMP_DEPTH    = 33;
   localparam int CMI_SWITCH_DEPTH  = 4;

   // unity gain code of contrast and saturation, 1/64 units
   localparam int CMI_GAIN_SHIFT = 6;
   localparam logic signed [9:0] CMI_BRIGHT_NOMINAL = 10'sd128;
endpackage

// [rtl/cmi_gain.sv]
`timescale 1ns/1ns
`default_nettype none
// signed 1/64 gain with saturation to 8 bits unsigned, plus optional offset
module cmi_gain
   import cmi_pkg::*;
#(
   parameter bit SIGNED_IN = 1'b0
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // sample path
   input  wire logic       [7:0] sample_in,
   input  wire logic       [7:0] gain,
   input  wire logic       [7:0] offset,
   output logic            [7:0] sample_out
);
   logic signed [9:0]  centred;
   logic signed [18:0] product;
   logic signed [18:0] shifted;
   logic signed [18:0] biased;

   always_comb begin
      // luma centred on black, chroma already signed about 128
      centred = SIGNED_IN ? ($signed({2'b00, sample_in}) - 10'sd128)
                          : $signed({2'b00, sample_in});
      product = centred * $signed(gain);
      shifted = product >>> CMI_GAIN_SHIFT;
      biased  = SIGNED_IN ? (shifted + 19'sd128)
                          : (shifted + 19'(offset) - 19'(CMI_BRIGHT_NOMINAL));
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sample_out <= 8'h00;
      end else if (biased < 0) begin
         sample_out <= 8'h00;
      end else if (biased > 19'sd255) begin
         sample_out <= 8'hff;
      end else begin
         sample_out <= biased[7:0];
      end
   end
endmodule
`default_nettype wire

// [rtl/cmi_delay.sv]
`timescale 1ns/1ns
`default_nettype none
// tapped shift line; selected tap becomes the output
module cmi_delay #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   // data
   input  wire logic [WIDTH-1:0]         din,
   input  wire logic [$clog2(DEPTH)-1:0] tap,
   output logic      [WIDTH-1:0]         dout
);
   logic [WIDTH-1:0] line_q [DEPTH];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) line_q[i] <= '0;
      end else begin
         line_q[0] <= din;
         for (int i = 1; i < DEPTH; i++) line_q[i] <= line_q[i-1];
      end
   end

   assign dout = line_q[tap];
endmodule
`default_nettype wire

// [rtl/cmi_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module cmi_regs
   import cmi_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // video samples
   input  wire logic [7:0] cvbs_y,
   input  wire logic [7:0] cvbs_c,
   input  wire logic [7:0] comp_y,
   input  wire logic [7:0] comp_c,
   input  wire logic       pixel_switch_input,
   output logic      [7:0] video_y,
   output logic      [7:0] video_c,
   output logic            comp_selected,
   // status flags from the decoder
   input  wire logic [2:0] slicer_flags,
   input  wire logic       formatter_error,
   input  wire logic       hpll_lock,
   input  wire logic [1:0] colour_std_change,
   output logic            irq_request
);
   logic [7:0] ctrl_q;
   logic [7:0] bright_q;
   logic [7:0] contrast_q;
   logic [7:0] sat_q;
   logic [7:0] mask1_q;
   logic [7:0] mask2_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return reg_wr && (a == ofs);
   endfunction

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= CMI_RST_DELAY_SWITCH;
      end else if (hit(reg_addr, CMI_OFS_DELAY_SWITCH)) begin
         ctrl_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         bright_q   <= CMI_RST_BRIGHTNESS;
         contrast_q <= CMI_RST_CONTRAST;
         sat_q      <= CMI_RST_SATURATION;
      end else begin
         if (hit(reg_addr, CMI_OFS_BRIGHTNESS)) bright_q <= reg_wdata;
         if (hit(reg_addr, CMI_OFS_CONTRAST)) contrast_q <= reg_wdata;
         if (hit(reg_addr, CMI_OFS_SATURATION)) sat_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask1_q <= CMI_RST_MASK;
         mask2_q <= CMI_RST_MASK;
      end else begin
         if (hit(reg_addr, CMI_OFS_MASK_FIRST)) mask1_q <= reg_wdata & CMI_MASK_FIRST_BITS;
         if (hit(reg_addr, CMI_OFS_MASK_SECOND)) mask2_q <= reg_wdata & CMI_MASK_SECOND_BITS;
      end
   end

   // unmapped offsets read as zero, so software can probe safely
   always_comb begin
      unique case (reg_addr)
         CMI_OFS_DELAY_SWITCH: reg_rdata = ctrl_q;
         CMI_OFS_BRIGHTNESS:   reg_rdata = bright_q;
         CMI_OFS_CONTRAST:     reg_rdata = contrast_q;
         CMI_OFS_SATURATION:   reg_rdata = sat_q;
         CMI_OFS_MASK_FIRST:   reg_rdata = mask1_q;
         CMI_OFS_MASK_SECOND:  reg_rdata = mask2_q;
         default:              reg_rdata = 8'h00;
      endcase
   end

   // control fields
   logic       pixel_switch_enable;
   logic       pixel_switch_polarity;
   logic [1:0] switch_input_delay;
   logic       component_luma_peaking;
   logic [2:0] comp_delay;
   assign pixel_switch_enable    = ctrl_q[CMI_BIT_SWITCH_ENABLE];
   assign pixel_switch_polarity  = ctrl_q[CMI_BIT_SWITCH_POLARITY];
   assign switch_input_delay     = ctrl_q[CMI_POS_SWITCH_DELAY +: 2];
   assign component_luma_peaking = ctrl_q[CMI_BIT_LUMA_PEAKING];
   assign comp_delay             = ctrl_q[CMI_POS_COMP_DELAY +: 3];

   // pin input: two flops before use
   logic sw_meta_q;
   logic sw_sync_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_meta_q <= 1'b0;
         sw_sync_q <= 1'b0;
      end else begin
         sw_meta_q <= pixel_switch_input;
         sw_sync_q <= sw_meta_q;
      end
   end

   // switch delay taps about the centre; later tap = less advance
   logic [1:0] sw_tap;
   always_comb begin
      unique case (switch_input_delay)
         2'b00:   sw_tap = 2'(CMI_SWITCH_CENTRE);
         2'b01:   sw_tap = 2'(CMI_SWITCH_CENTRE + 1);
         2'b10:   sw_tap = 2'(CMI_SWITCH_CENTRE - 2);
         default: sw_tap = 2'(CMI_SWITCH_CENTRE - 1);
      endcase
   end

   logic sw_delayed;
   cmi_delay #(.WIDTH(1), .DEPTH(CMI_SWITCH_DEPTH)) u_sw_delay (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .din     (sw_sync_q),
      .tap     (sw_tap),
      .dout    (sw_delayed)
   );

   // component delay in steps of four pixels, signed code
   logic [5:0] comp_tap;
   assign comp_tap = 6'(CMI_COMP_CENTRE) + {{1{comp_delay[2]}}, comp_delay, 2'b00};

   logic [15:0] comp_delayed;
   cmi_delay #(.WIDTH(16), .DEPTH(CMI_COMP_DEPTH)) u_comp_delay (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .din     ({comp_y, comp_c}),
      .tap     (comp_tap),
      .dout    (comp_delayed)
   );

   // composite path aligned to the centre of the component line
   logic [15:0] cvbs_delayed;
   cmi_delay #(.WIDTH(16), .DEPTH(CMI_COMP_DEPTH)) u_cvbs_delay (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .din     ({cvbs_y, cvbs_c}),
      .tap     (6'(CMI_COMP_CENTRE)),
      .dout    (cvbs_delayed)
   );

   // luma peaking: y + (2y - left - right)/8, roughly +1.5 dB near 5 MHz
   logic [7:0] y_prev_q;
   logic [7:0] y_cur_q;
   logic [7:0] y_peak_q;
   logic signed [11:0] peak_sum;
   always_comb begin
      peak_sum = $signed({4'h0, y_cur_q})
               + (($signed({3'h0, y_cur_q, 1'b0}) - $signed({4'h0, y_prev_q})
                   - $signed({4'h0, comp_delayed[15:8]})) >>> 3);
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         y_prev_q <= 8'h00;
         y_cur_q  <= 8'h00;
         y_peak_q <= 8'h00;
      end else begin
         y_prev_q <= y_cur_q;
         y_cur_q  <= comp_delayed[15:8];
         if (!component_luma_peaking) begin
            y_peak_q <= y_cur_q;
         end else if (peak_sum < 0) begin
            y_peak_q <= 8'h00;
         end else if (peak_sum > 12'sd255) begin
            y_peak_q <= 8'hff;
         end else begin
            y_peak_q <= peak_sum[7:0];
         end
      end
   end

   // matching two-cycle delay for chroma
   logic [7:0] c_d1_q;
   logic [7:0] c_d2_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         c_d1_q <= 8'h00;
         c_d2_q <= 8'h00;
      end else begin
         c_d1_q <= comp_delayed[7:0];
         c_d2_q <= c_d1_q;
      end
   end

   logic [7:0] comp_y_adj;
   logic [7:0] comp_c_adj;
   cmi_gain #(.SIGNED_IN(1'b0)) u_luma_gain (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .sample_in  (y_peak_q),
      .gain       (contrast_q),
      .offset     (bright_q),
      .sample_out (comp_y_adj)
   );
   cmi_gain #(.SIGNED_IN(1'b1)) u_chroma_gain (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .sample_in  (c_d2_q),
      .gain       (sat_q),
      .offset     (8'h00),
      .sample_out (comp_c_adj)
   );

   // composite aligned to the three-cycle component adjust pipe
   logic [15:0] cvbs_p1_q;
   logic [15:0] cvbs_p2_q;
   logic [15:0] cvbs_p3_q;
   logic [2:0]  sw_pipe_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cvbs_p1_q <= 16'h0000;
         cvbs_p2_q <= 16'h0000;
         cvbs_p3_q <= 16'h0000;
         sw_pipe_q <= 3'h0;
      end else begin
         cvbs_p1_q <= cvbs_delayed;
         cvbs_p2_q <= cvbs_p1_q;
         cvbs_p3_q <= cvbs_p2_q;
         sw_pipe_q <= {sw_pipe_q[1:0], sw_delayed};
      end
   end

   // static bit is set by software per input mode
   logic use_comp;
   always_comb begin
      if (pixel_switch_enable) begin
         use_comp = sw_pipe_q[2] ^ pixel_switch_polarity;
      end else begin
         use_comp = ctrl_q[CMI_BIT_STATIC_SELECT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         video_y       <= 8'h00;
         video_c       <= 8'h00;
         comp_selected <= 1'b0;
      end else begin
         video_y       <= use_comp ? comp_y_adj : cvbs_p3_q[15:8];
         video_c       <= use_comp ? comp_c_adj : cvbs_p3_q[7:0];
         comp_selected <= use_comp;
      end
   end

   // flag change detection, all flags are same-clock decoder logic
   logic [7:0] flags;
   logic [7:0] flags_q;
   logic [7:0] en;
   wire  logic [7:0] flag_hit;
   assign flags = {formatter_error, hpll_lock, slicer_flags, colour_std_change, 1'b0};
   assign en    = {mask1_q[0],
                   mask2_q[6],
                   mask1_q[4:2],
                   mask2_q[1:0],
                   1'b0};

   // one change detector per flag position
   for (genvar g = 0; g < 8; g++) begin : g_flag_hit
      assign flag_hit[g] = (flags[g] ^ flags_q[g]) & en[g];
   end

   // history follows masked flags too, so a later unmask never fires on a stale change
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= 8'h00;
      end else begin
         flags_q <= flags;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= |flag_hit;
      end
   end
endmodule
`default_nettype wire

// [testbench/cmi_regs_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module cmi_regs_sva
   import cmi_pkg::*;
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // switching
   input wire logic       pixel_switch_input,
   input wire logic       comp_selected,
   // status flags
   input wire logic [2:0] slicer_flags,
   input wire logic       formatter_error,
   input wire logic       hpll_lock,
   input wire logic [1:0] colour_std_change,
   input wire logic       irq_request
);
   logic [7:0] ctrl_q;
   logic [7:0] m1_q;
   logic [7:0] m2_q;
   logic [6:0] flg_q;
   logic       pin_q;
   logic [5:0] quiet_q;
   wire  [6:0] flg = {slicer_flags, formatter_error, hpll_lock, colour_std_change};
   wire  [6:0] en  = {m1_q[4:2], m1_q[0], m2_q[6], m2_q[1:0]};
   wire  [6:0] chg = (flg ^ flg_q) & en;

   // shadow of the control and mask registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 8'h00;
         m1_q <= 8'h00;
         m2_q <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == CMI_OFS_DELAY_SWITCH) ctrl_q <= reg_wdata;
         if (reg_addr == CMI_OFS_MASK_FIRST) m1_q <= reg_wdata;
         if (reg_addr == CMI_OFS_MASK_SECOND) m2_q <= reg_wdata;
      end
   end

   // settle counter: pipelines are far shorter than 63 cycles
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flg_q <= 7'h00;
         pin_q <= 1'b0;
         quiet_q <= 6'h00;
      end else begin
         flg_q <= flg;
         pin_q <= pixel_switch_input;
         if ((reg_wr && reg_addr == CMI_OFS_DELAY_SWITCH) || pin_q != pixel_switch_input)
            quiet_q <= 6'h00;
         else if (quiet_q != 6'h3f)
            quiet_q <= quiet_q + 6'h01;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_wr(a);
      reg_wr && reg_addr == a ##1 !reg_wr && reg_addr == a;
   endsequence

   property p_ctrl_rd;   s_wr(CMI_OFS_DELAY_SWITCH) |-> reg_rdata == $past(reg_wdata); endproperty
   property p_bright_rd; s_wr(CMI_OFS_BRIGHTNESS) |-> reg_rdata == $past(reg_wdata); endproperty
   property p_con_rd;    s_wr(CMI_OFS_CONTRAST) |-> reg_rdata == $past(reg_wdata); endproperty
   property p_sat_rd;    s_wr(CMI_OFS_SATURATION) |-> reg_rdata == $past(reg_wdata); endproperty
   property p_m1_rd;     reg_addr == 8'h2d |-> reg_rdata == (m1_q & 8'h1d); endproperty
   property p_m2_rd;     reg_addr == 8'h2e |-> reg_rdata == (m2_q & 8'h43); endproperty
   property p_irq_slc;   |chg[6:4] |=> irq_request; endproperty
   property p_irq_fmt;   chg[3] |=> irq_request; endproperty
   property p_irq_hpll;  chg[2] |=> irq_request; endproperty
   property p_irq_std;   |chg[1:0] |=> irq_request; endproperty
   property p_irq_only;  irq_request |-> $past(|chg); endproperty
   property p_static;
      quiet_q == 6'h3f && !ctrl_q[7] |-> comp_selected == ctrl_q[6];
   endproperty
   property p_pixel;
      quiet_q == 6'h3f && ctrl_q[7] |-> comp_selected == (pixel_switch_input ^ ctrl_q[6]);
   endproperty

   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
   a_bright_rd: assert property (p_bright_rd) else $error("brightness readback wrong");
   a_con_rd: assert property (p_con_rd) else $error("contrast readback wrong");
   a_sat_rd: assert property (p_sat_rd) else $error("saturation readback wrong");
   a_m1_rd: assert property (p_m1_rd) else $error("first mask readback wrong");
   a_m2_rd: assert property (p_m2_rd) else $error("second mask readback wrong");
   a_irq_slc: assert property (p_irq_slc) else $error("slicer irq missing");
   a_irq_fmt: assert property (p_irq_fmt) else $error("formatter irq missing");
   a_irq_hpll: assert property (p_irq_hpll) else $error("lock irq missing");
   a_irq_std: assert property (p_irq_std) else $error("standard irq missing");
   a_irq_only: assert property (p_irq_only) else $error("irq without enabled change");
   a_static: assert property (p_static) else $error("static select wrong");
   a_pixel: assert property (p_pixel) else $error("pixel switch wrong");
endmodule
`default_nettype wire

// [testbench/cmi_regs_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module cmi_regs_test
   import cmi_pkg::*;
;
   logic       ref_clk;
   logic       rst_b;
   logic [7:0] reg_addr;
   logic       reg_wr;
   logic [7:0] reg_wdata;
   logic [7:0] cvbs_y, cvbs_c, comp_y, comp_c;
   logic       pixel_switch_input;
   logic [6:0] flg;
   wire  [7:0] reg_rdata, video_y, video_c;
   wire        comp_selected, irq_request;
   int         num_errors = 0;
   int         samples_checked = 0;
   logic [7:0] ofs [8] = '{8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h28, 8'h2f};
   logic [7:0] rv [8] = '{8'h00, 8'h80, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] mb [7] = '{8'h01, 8'h02, 8'h40, 8'h01, 8'h04, 8'h08, 8'h10};
   logic [15:0] hc [40];
   logic [15:0] hm [40];
   logic        hp [16];

   cmi_regs u_cmi_regs (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cvbs_y(cvbs_y),
      .cvbs_c(cvbs_c), .comp_y(comp_y), .comp_c(comp_c),
      .pixel_switch_input(pixel_switch_input), .video_y(video_y), .video_c(video_c),
      .comp_selected(comp_selected), .slicer_flags(flg[6:4]), .formatter_error(flg[3]),
      .hpll_lock(flg[2]), .colour_std_change(flg[1:0]), .irq_request(irq_request));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // live random samples keep the video path busy; histories hold what the design sampled
   always @(posedge ref_clk) begin
      cvbs_y <= 8'($urandom);
      cvbs_c <= 8'($urandom);
      comp_y <= 8'($urandom);
      comp_c <= 8'($urandom);
      hc[0] <= {cvbs_y, cvbs_c};
      hm[0] <= {comp_y, comp_c};
      hp[0] <= pixel_switch_input;
      for (int k = 1; k < 40; k++) begin
         hc[k] <= hc[k-1];
         hm[k] <= hm[k-1];
      end
      for (int k = 1; k < 16; k++) hp[k] <= hp[k-1];
   end

   function automatic logic [7:0] sat8(input int v);
      sat8 = (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
   endfunction

   // 1/64 gains; brightness 128 is nominal, chroma is signed about 128
   function automatic logic [15:0] cexp(input logic [15:0] s, input logic [7:0] g,
                                        input logic [7:0] o, input logic [7:0] sg);
      int y;
      int c;
      y = (int'(s[15:8]) * int'($signed(g))) >>> 6;
      c = ((int'(s[7:0]) - 128) * int'($signed(sg))) >>> 6;
      cexp = {sat8(y + int'(o) - 128), sat8(c + 128)};
   endfunction

   function automatic logic [7:0] peak(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] n);
      peak = sat8(int'(b) + ((2 * int'(b) - int'(a) - int'(n)) >>> 3));
   endfunction

   function automatic int soff(input logic [1:0] f);
      case (f)
         2'b00: soff = 0;
         2'b01: soff = 1;
         2'b10: soff = -2;
         default: soff = -1;
      endcase
   endfunction

   function automatic logic [7:0] rexp(input logic [7:0] a, input logic [7:0] d);
      case (a)
         8'h29, 8'h2a, 8'h2b, 8'h2c: rexp = d;
         8'h2d: rexp = d & 8'h1d;
         8'h2e: rexp = d & 8'h43;
         default: rexp = 8'h00;
      endcase
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      @(negedge ref_clk);
      `CHK("reg_rdata", e, reg_rdata)
   endtask

   task automatic flip(input int i, input logic e);
      @(posedge ref_clk);
      flg[i] <= ~flg[i];
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("irq_request", e, irq_request)
      @(negedge ref_clk);
      `CHK("irq_request", 1'b0, irq_request)
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      $display("ERROR watchdog expected finish seen hang");
      test_done();
   end

   initial begin
      logic [7:0] d, c;
      logic [7:0] shadow [8];
      logic [7:0]  gv [3];
      logic [15:0] e;
      logic [7:0]  y;
      logic        sel;
      int          ix;
      void'($urandom(32'h1388bec5));
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      pixel_switch_input = 1'b0;
      flg = 7'h00;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) rd(ofs[i], rv[i]);
      $display("test reset values done");
      // all ones, all zeros, then random; unmapped places must stay silent
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 8; i++) begin
            d = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : 8'($urandom);
            wr(ofs[i], d);
            shadow[i] = rexp(ofs[i], d);
            rd(ofs[i], shadow[i]);
         end
         for (int i = 0; i < 8; i++) rd(ofs[i], shadow[i]);
      end
      wr(8'h2d, 8'h00);
      wr(8'h2e, 8'h00);
      $display("test register access done");
      for (int i = 0; i < 7; i++) begin
         for (int on = 0; on < 2; on++) begin
            wr((i > 2) ? 8'h2d : 8'h2e, on[0] ? mb[i] : 8'h00);
            flip(i, on[0]);
            flip(i, on[0]);
         end
         wr((i > 2) ? 8'h2d : 8'h2e, 8'h00);
      end
      $display("test interrupt masks done");
      // static select 0 or 1 by input mode, then pixel switching both senses
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            c = {m[1:0], 6'h00} | (8'($urandom) & 8'h3f);
            wr(8'h29, c);
            pixel_switch_input <= p[0];
            repeat (70) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK("comp_selected", c[7] ? (p[0] ^ c[6]) : c[6], comp_selected)
         end
      end
      $display("test switch select done");
      // video path: both sources, pixel switching, random delay codes, gain corners
      for (int t = 0; t < 16; t++) begin
         c = (t == 0) ? 8'h40 : (t == 1) ? 8'h48 : 8'($urandom);
         gv[0] = (t == 0) ? 8'h80 : (t == 1) ? 8'h00 : 8'($urandom);
         gv[1] = (t == 0) ? 8'h40 : (t == 1) ? 8'h7f : 8'($urandom);
         gv[2] = (t == 0) ? 8'h40 : (t == 1) ? 8'h80 : 8'($urandom);
         wr(8'h29, c);
         for (int k = 0; k < 3; k++) wr(8'h2a + 8'(k), gv[k]);
         for (int k = 0; k < 50; k++) begin
            pixel_switch_input <= 1'($urandom);
            @(negedge ref_clk);
            ix = 20 + 4 * int'($signed(c[2:0]));
            y = c[3] ? peak(hm[ix+1][15:8], hm[ix][15:8], hm[ix-1][15:8]) : hm[ix][15:8];
            sel = c[7] ? (hp[8 + soff(c[5:4])] ^ c[6]) : c[6];
            e = sel ? cexp({y, hm[ix][7:0]}, gv[1], gv[0], gv[2]) : hc[20];
            if (k >= 30) begin
               `CHK("comp_selected", sel, comp_selected)
               `CHK("video", e, {video_y, video_c})
            end
            @(posedge ref_clk);
         end
      end
      $display("test video path done");
      test_done();
   end
endmodule

bind cmi_regs cmi_regs_sva u_cmi_regs_sva (.ref_clk(ref_clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .pixel_switch_input(pixel_switch_input), .comp_selected(comp_selected),
   .slicer_flags(slicer_flags), .formatter_error(formatter_error), .hpll_lock(hpll_lock),
   .colour_std_change(colour_std_change), .irq_request(irq_request));
`default_nettype wire
